// ==== src/rda_pkg.sv ====
package rda_pkg;

  // ****************************************
  // register indices, byte address = 4 * index
  // ****************************************
  localparam logic [3:0] RDA_IDX_WEEKDAY_CNT = 4'h3;
  localparam logic [3:0] RDA_IDX_W_MINUTE    = 4'h8;
  localparam logic [3:0] RDA_IDX_W_HOUR      = 4'h9;
  localparam logic [3:0] RDA_IDX_W_DAYMASK   = 4'ha;
  localparam logic [3:0] RDA_IDX_D_MINUTE    = 4'hb;
  localparam logic [3:0] RDA_IDX_D_HOUR      = 4'hc;
  localparam logic [3:0] RDA_IDX_CONTROL     = 4'he;
  localparam logic [4:0] RDA_IDX_STATUS      = 5'h10;
  localparam logic [4:0] RDA_IDX_MASK        = 5'h11;

  // ****************************************
  // field layout
  // ****************************************
  localparam int RDA_MIN_W       = 7;
  localparam int RDA_HOUR_W      = 6;
  localparam int RDA_DAYS_W      = 7;
  localparam int RDA_WDAY_W      = 3;
  localparam int RDA_HOUR_PM_BIT = 5;
  localparam int RDA_CTRL_24H_BIT = 5;
  localparam int RDA_ST_WEEKLY   = 0;
  localparam int RDA_ST_DAILY    = 1;
  localparam int RDA_ST_W        = 2;

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [6:0] RDA_MIN_RST     = 7'h00;
  localparam logic [5:0] RDA_HOUR_RST    = 6'h00;
  localparam logic [6:0] RDA_DAYS_RST    = 7'h00;
  localparam logic [2:0] RDA_WDAY_RST    = 3'h0;
  localparam logic [2:0] RDA_WDAY_LAST   = 3'h6;
  localparam logic [1:0] RDA_STATUS_RST  = 2'h0;
  localparam logic       RDA_MODE24_RST  = 1'b1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
  } rda_time_t;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [6:0] days;
  } rda_weekly_t;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
  } rda_daily_t;

  typedef enum logic [1:0] {
    RDA_APB_IDLE   = 2'b00,
    RDA_APB_SETUP  = 2'b01,
    RDA_APB_ACCESS = 2'b10
  } rda_apb_phase_t;

endpackage : rda_pkg

// ==== src/rda_alarm_compare.sv ====
`timescale 1ns/1ps
// Behaviour
// [R1] weekly minute: bcd tens bits 6..4, units 3..0, bit 7 reads zero
// [R2] weekly hour: six bits 5..0 stored, bits 7..6 read zero
// [R3] weekday mask: seven enable bits 6..0, bit 7 reads zero
// [R4] daily minute: bcd tens bits 6..4, units 3..0, bit 7 reads zero
// [R5] daily hour: six bits 5..0 stored, bits 7..6 read zero
// [R6] after power-up fields arbitrary, unused bits always read zero
// [R7] weekly hour bit 5 is pm flag or tens-two per mode
// [R8] daily hour bit 5 is pm flag or tens-two per mode
// [R9] 12-hour midnight is 12h and noon 32h, same as counter
// [R10] enable bit n matches weekday code n, codes 0 to 6
// [R11] all enables zero means weekly alarm never matches
// [R12] software writes only existing bcd times into alarm fields
// [R13] match only on exact hour and minute, enabled day for weekly
// [R14] weekday codes purely numeric, day meaning left to software
// [R15] weekday counter counts 0 to 6 then wraps, once per day carry
// [R16] alarm hour meaning follows the 12/24 mode bit of control
// [R17] compare on every minute update, one match pulse per alarm
// [R18] alarm writes apply to next compare, counters untouched
module rda_alarm_compare
  import rda_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire rda_time_t   cur_time,
  input  wire logic        minute_tick,
  input  wire logic        day_carry,
  output logic [2:0]       weekday_code,
  output logic             hour_mode_24,
  output logic             weekly_match,
  output logic             daily_match,
  output logic             irq
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [7:0] rda_byte_addr(input logic [4:0] idx);
    rda_byte_addr = {1'b0, idx, 2'b00};
  endfunction : rda_byte_addr

  function automatic logic rda_time_eq(input rda_time_t now_t,
                                       input logic [6:0] pre_min,
                                       input logic [5:0] pre_hour);
    rda_time_eq = (now_t.minute == pre_min) && (now_t.hour == pre_hour);
  endfunction : rda_time_eq

  // ****************************************
  // state
  // ****************************************
  rda_weekly_t      weekly_r;
  rda_weekly_t      weekly_nxt;
  rda_daily_t       daily_r;
  rda_daily_t       daily_nxt;
  logic [2:0]       wday_r;
  logic [2:0]       wday_nxt;
  logic             mode24_r;
  logic             mode24_nxt;
  logic [1:0]       status_r;
  logic [1:0]       status_nxt;
  logic [1:0]       mask_r;
  logic [1:0]       mask_nxt;
  logic             wmatch_r;
  logic             dmatch_r;
  logic [31:0]      prdata_r;
  logic [31:0]      prdata_nxt;
  logic             perr_r;
  logic             perr_nxt;
  rda_apb_phase_t   phase;

  // ****************************************
  // bus decode
  // ****************************************
  wire setup_cyc   = psel & ~penable;
  wire access_cyc  = psel & penable;
  wire wr_en       = access_cyc & pwrite;
  wire hit_wday    = paddr == rda_byte_addr({1'b0, RDA_IDX_WEEKDAY_CNT});
  wire hit_wmin    = paddr == rda_byte_addr({1'b0, RDA_IDX_W_MINUTE});
  wire hit_whour   = paddr == rda_byte_addr({1'b0, RDA_IDX_W_HOUR});
  wire hit_wdays   = paddr == rda_byte_addr({1'b0, RDA_IDX_W_DAYMASK});
  wire hit_dmin    = paddr == rda_byte_addr({1'b0, RDA_IDX_D_MINUTE});
  wire hit_dhour   = paddr == rda_byte_addr({1'b0, RDA_IDX_D_HOUR});
  wire hit_ctrl    = paddr == rda_byte_addr({1'b0, RDA_IDX_CONTROL});
  wire hit_status  = paddr == rda_byte_addr(RDA_IDX_STATUS);
  wire hit_mask    = paddr == rda_byte_addr(RDA_IDX_MASK);
  wire hit_any     = hit_wday | hit_wmin | hit_whour | hit_wdays |
                     hit_dmin | hit_dhour | hit_ctrl | hit_status |
                     hit_mask;

  assign phase = setup_cyc  ? RDA_APB_SETUP  :
                 access_cyc ? RDA_APB_ACCESS : RDA_APB_IDLE;

  // ****************************************
  // compare logic
  // ****************************************
  // code 7 is not a day: no enable bit exists for it
  wire       wday_valid = wday_r <= RDA_WDAY_LAST;            // [R10]
  wire [7:0] day_sel    = 8'h01 << wday_r;                    // [R14]
  wire       day_on     = wday_valid &
                          (|(day_sel[6:0] & weekly_r.days));  // [R10] [R11]
  // raw equality: pm flag and tens-two bit compare alike
  wire       w_time_eq  = rda_time_eq(cur_time, weekly_r.minute,
                                      weekly_r.hour);         // [R7] [R9]
  wire       d_time_eq  = rda_time_eq(cur_time, daily_r.minute,
                                      daily_r.hour);          // [R8] [R9]
  wire       w_hit      = minute_tick & w_time_eq & day_on;   // [R13] [R17]
  wire       d_hit      = minute_tick & d_time_eq;            // [R13] [R17]

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    weekly_nxt = weekly_r;
    daily_nxt  = daily_r;
    mode24_nxt = mode24_r;
    mask_nxt   = mask_r;
    if (wr_en && hit_wmin) begin
      weekly_nxt.minute = pwdata[6:0];                        // [R1]
    end
    if (wr_en && hit_whour) begin
      weekly_nxt.hour = pwdata[5:0];                          // [R2]
    end
    if (wr_en && hit_wdays) begin
      weekly_nxt.days = pwdata[6:0];                          // [R3]
    end
    if (wr_en && hit_dmin) begin
      daily_nxt.minute = pwdata[6:0];                         // [R4]
    end
    if (wr_en && hit_dhour) begin
      daily_nxt.hour = pwdata[5:0];                           // [R5]
    end
    if (wr_en && hit_ctrl) begin
      mode24_nxt = pwdata[RDA_CTRL_24H_BIT];                  // [R16]
    end
    if (wr_en && hit_mask) begin
      mask_nxt = pwdata[RDA_ST_W-1:0];
    end
  end

  // weekday counter: software write wins over a day carry
  always_comb begin
    wday_nxt = wday_r;
    if (wr_en && hit_wday) begin
      wday_nxt = pwdata[2:0];
    end else if (day_carry) begin
      if (wday_r >= RDA_WDAY_LAST) begin
        wday_nxt = RDA_WDAY_RST;                              // [R15]
      end else begin
        wday_nxt = wday_r + 3'h1;                             // [R15]
      end
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_comb begin
    status_nxt = status_r;
    if (wr_en && hit_status) begin
      status_nxt = status_r & ~pwdata[RDA_ST_W-1:0];
    end
    if (w_hit) begin
      status_nxt[RDA_ST_WEEKLY] = 1'b1;
    end
    if (d_hit) begin
      status_nxt[RDA_ST_DAILY] = 1'b1;
    end
  end

  // read data sampled in setup, stable through access
  always_comb begin
    prdata_nxt = prdata_r;
    perr_nxt   = 1'b0;
    if (phase == RDA_APB_SETUP) begin
      perr_nxt   = ~hit_any;
      prdata_nxt = 32'h0000_0000;
      case (1'b1)
        hit_wday:   prdata_nxt = {29'h0, wday_r};
        hit_wmin:   prdata_nxt = {25'h0, weekly_r.minute};    // [R1] [R6]
        hit_whour:  prdata_nxt = {26'h0, weekly_r.hour};      // [R2] [R6]
        hit_wdays:  prdata_nxt = {25'h0, weekly_r.days};      // [R3] [R6]
        hit_dmin:   prdata_nxt = {25'h0, daily_r.minute};     // [R4] [R6]
        hit_dhour:  prdata_nxt = {26'h0, daily_r.hour};       // [R5] [R6]
        hit_ctrl:   prdata_nxt = {26'h0, mode24_r, 5'h00};
        hit_status: prdata_nxt = {30'h0, status_r};
        hit_mask:   prdata_nxt = {30'h0, mask_r};
        default:    prdata_nxt = 32'h0000_0000;
      endcase
    end else if (phase == RDA_APB_ACCESS) begin
      perr_nxt = perr_r;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      weekly_r <= '{minute: RDA_MIN_RST, hour: RDA_HOUR_RST,
                    days: RDA_DAYS_RST};
      daily_r  <= '{minute: RDA_MIN_RST, hour: RDA_HOUR_RST};
    end else begin
      weekly_r <= weekly_nxt;                                 // [R18]
      daily_r  <= daily_nxt;                                  // [R18]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wday_r   <= RDA_WDAY_RST;
      mode24_r <= RDA_MODE24_RST;
      status_r <= RDA_STATUS_RST;
      mask_r   <= RDA_STATUS_RST;
    end else begin
      wday_r   <= wday_nxt;
      mode24_r <= mode24_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wmatch_r <= 1'b0;
      dmatch_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      perr_r   <= 1'b0;
    end else begin
      wmatch_r <= w_hit;                                      // [R17]
      dmatch_r <= d_hit;                                      // [R17]
      prdata_r <= prdata_nxt;
      perr_r   <= perr_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready       = 1'b1;
  assign pslverr      = access_cyc & perr_r;
  assign prdata       = prdata_r;
  assign weekday_code = wday_r;
  assign hour_mode_24 = mode24_r;
  assign weekly_match = wmatch_r;
  assign daily_match  = dmatch_r;
  assign irq          = |(status_r & mask_r);

endmodule : rda_alarm_compare

// ==== tb/rda_props.sv ====
`timescale 1ns/1ps
module rda_props
  import rda_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        minute_tick,
  input wire logic        day_carry,
  input wire logic [2:0]  weekday_code,
  input wire logic        weekly_match,
  input wire logic        daily_match,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  wire wday_wr = wr && paddr == 8'h0c;
  sequence s_carry;
    day_carry && !wday_wr;
  endsequence
  AST_WEEKLY_CAUSE: assert property (weekly_match |->
    $past(minute_tick) && $past(weekday_code) <= 3'h6)
    else $error("weekly match without tick");
  AST_DAILY_CAUSE: assert property (daily_match |-> $past(minute_tick))
    else $error("daily match without tick");
  AST_WDAY_INC: assert property (s_carry ##0 weekday_code < 3'h6 |=>
    weekday_code == $past(weekday_code) + 3'h1)
    else $error("weekday did not advance");
  AST_WDAY_WRAP: assert property (s_carry ##0 weekday_code == 3'h6 |=>
    weekday_code == 3'h0) else $error("weekday did not wrap");
  AST_WDAY_HOLD: assert property (!day_carry && !wday_wr |=>
    $stable(weekday_code)) else $error("weekday moved");
  AST_RD_MIN_TOP: assert property (rd && paddr inside
    {8'h20, 8'h28, 8'h2c} |-> prdata[31:7] == 25'h0)
    else $error("minute or mask top bits set");
  AST_RD_HOUR_TOP: assert property (rd && paddr inside
    {8'h24, 8'h30} |-> prdata[31:6] == 26'h0)
    else $error("hour top bits set");
  AST_IRQ_RISE: assert property ($rose(irq) |-> weekly_match ||
    daily_match || $past(wr && paddr == 8'h44))
    else $error("irq rose without cause");
endmodule : rda_props
bind rda_alarm_compare rda_props i_rda_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .prdata(prdata),
  .minute_tick(minute_tick), .day_carry(day_carry),
  .weekday_code(weekday_code), .weekly_match(weekly_match),
  .daily_match(daily_match), .irq(irq));

// ==== tb/rda_host.sv ====
`timescale 1ns/1ps
module rda_host (
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ****************************************
  // one apb transfer, bounded wait on pready
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err, output logic ok);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && ok !== 1'b1; n++) begin
      @(posedge ref_clk);
      ok = pready;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show a changed value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : rda_host

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import rda_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e, ok, minute_tick;
  logic day_carry, hour_mode_24, weekly_match, daily_match, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] weekday_code;
  rda_time_t cur_time;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] ra [6] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h50};
  logic [31:0] rr [6] = '{32'h7f, 32'h3f, 32'h7f, 32'h7f, 32'h3f, 32'h0};
  always #12.5 ref_clk = ~ref_clk;
  rda_alarm_compare i_rda_alarm_compare (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cur_time(cur_time), .minute_tick(minute_tick), .day_carry(day_carry),
    .weekday_code(weekday_code), .hour_mode_24(hour_mode_24),
    .weekly_match(weekly_match), .daily_match(daily_match), .irq(irq));
  rda_host i_rda_host (.ref_clk(ref_clk), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_rda_host.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : bus
  task tick(input logic [6:0] m, input logic [5:0] h, input logic w,
            input logic d);
    @(posedge ref_clk);
    cur_time <= {m, h};
    minute_tick <= 1'b1;
    @(posedge ref_clk);
    minute_tick <= 1'b0;
    #1 chk(weekly_match, w);
    chk(daily_match, d);
  endtask : tick
  initial begin
    cur_time = '0;
    minute_tick = 1'b0;
    day_carry = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(hour_mode_24, 1'b1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, 32'h0);
      bus(1'b1, ra[i], 32'hff);
      bus(1'b0, ra[i], 32'h0);
      chk(q, rr[i]);
      chk(e, i == 5);
    end
    bus(1'b1, 8'h20, 32'h30);
    bus(1'b1, 8'h24, 32'h32);
    bus(1'b1, 8'h28, 32'h02);
    bus(1'b1, 8'h2c, 32'h59);
    bus(1'b1, 8'h30, 32'h23);
    tick(7'h30, 6'h32, 1'b0, 1'b0);
    bus(1'b1, 8'h0c, 32'h1);
    tick(7'h30, 6'h32, 1'b1, 1'b0);
    tick(7'h31, 6'h32, 1'b0, 1'b0);
    tick(7'h30, 6'h12, 1'b0, 1'b0);
    tick(7'h59, 6'h23, 1'b0, 1'b1);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h3);
    chk(irq, 1'b0);
    bus(1'b1, 8'h44, 32'h3);
    #1 chk(irq, 1'b1);
    bus(1'b1, 8'h40, 32'h3);
    #1 chk(irq, 1'b0);
    bus(1'b1, 8'h28, 32'h0);
    tick(7'h30, 6'h32, 1'b0, 1'b0);
    bus(1'b1, 8'h38, 32'h0);
    #1 chk(hour_mode_24, 1'b0);
    bus(1'b1, 8'h0c, 32'h5);
    @(posedge ref_clk);
    day_carry <= 1'b1;
    repeat (2) @(posedge ref_clk);
    day_carry <= 1'b0;
    #1 chk(weekday_code, 3'h0);
    results();
  end
endmodule : testbench
